// [bench/spi_hdr_decoder_test.sv]
`timescale 1ns/1ps

module spi_hdr_decoder_test;
	logic clk_sys, rst, wb_cyc, wb_stb, wb_we, wb_ack, miso, miso_oe, mem_ack;
	logic [7:0] wb_adr, mem_rdata;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat, wb_rdat;
	wire logic sclk, sel_n, mosi;
	wire logic miso_line;
	spi_hdr_pkg::mem_req_t mem_req;
	int error_cnt, tests_run;
	logic [31:0] q_addr[$];
	logic [7:0] q_data[$];

	spi_hdr_decoder spi_hdr_decoder_inst (.i_clk_sys(clk_sys), .i_rst(rst), .i_wb_cyc(wb_cyc),
		.i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel),
		.i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_sclk(sclk),
		.i_slave_select_n(sel_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
		.o_mem_req(mem_req), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata));
	spi_host_model spi_host_model_inst (.o_sclk(sclk), .o_slave_select_n(sel_n),
		.o_mosi(mosi), .i_miso(miso_line));

	// a deselected slave leaves the line floating; the host then sees the inverse
	assign miso_line = miso_oe ? miso : ~miso;

	always #4 clk_sys = ~clk_sys;

	function automatic logic [7:0] mem_val(input logic [31:0] a);
		return a[7:0] ^ 8'h3C;
	endfunction

	// memory answers one cycle after a request, logs every write
	always @(posedge clk_sys) begin
		mem_ack <= mem_req.valid && !mem_ack;
		mem_rdata <= (mem_req.valid && !mem_ack) ? mem_val(mem_req.addr) : ~mem_rdata;
		if (mem_req.valid && mem_ack && mem_req.we) begin
			q_addr.push_back(mem_req.addr);
			q_data.push_back(mem_req.wdata);
		end
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// oldest logged write must match
	task automatic chk_wr(input logic [31:0] adr, input logic [7:0] dat);
		if (q_addr.size() == 0) begin
			chk(32'h0000_0000, 32'h0000_0001);
		end else begin
			chk(q_addr.pop_front(), adr);
			chk({24'h00_0000, q_data.pop_front()}, {24'h00_0000, dat});
		end
	endtask

	// classic single cycle, held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		wb_sel <= 4'hF;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
	endtask

	initial begin
		#400000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		logic [31:0] rd;
		logic [7:0] rx;
		clk_sys = 1'b0;
		rst = 1'b1;
		{wb_cyc, wb_stb, wb_we, mem_ack} = 4'h0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = 32'h0000_0000;
		mem_rdata = 8'h00;
		error_cnt = 0;
		tests_run = 0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		// reset values and an unmapped place
		wb_xfer(1'b0, spi_hdr_pkg::REG_CTRL, 32'h0000_0000, rd);
		chk(rd, {30'h0000_0000, spi_hdr_pkg::CTRL_RESET});
		wb_xfer(1'b0, spi_hdr_pkg::REG_BASE, 32'h0000_0000, rd);
		chk(rd, spi_hdr_pkg::BASE_RESET);
		wb_xfer(1'b0, 8'h20, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		// short write, non-burst, select released between bytes
		wb_xfer(1'b1, spi_hdr_pkg::REG_BASE, 32'h5A5A_1234, rd);
		spi_host_model_inst.frame_open();
		spi_host_model_inst.send_short(16'h0010, 8'h80, 8'h02);
		spi_host_model_inst.frame_close();
		spi_host_model_inst.frame_open();
		spi_host_model_inst.xfer(8'hA1, rx);
		spi_host_model_inst.frame_close();
		spi_host_model_inst.frame_open();
		spi_host_model_inst.xfer(8'hB2, rx);
		spi_host_model_inst.frame_close();
		chk_wr(32'h1234_0010, 8'hA1);
		chk_wr(32'h1234_0011, 8'hB2);
		chk(32'(q_addr.size()), 32'h0000_0000);
		// burst, common base, upper length bits, abort after one byte
		wb_xfer(1'b1, spi_hdr_pkg::REG_CTRL, 32'h0000_0003, rd);
		spi_host_model_inst.frame_open();
		spi_host_model_inst.send_short(16'h0200, 8'h21, 8'h02);
		spi_host_model_inst.xfer(8'h33, rx);
		wb_xfer(1'b0, spi_hdr_pkg::REG_LAST_LEN, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0101);
		spi_host_model_inst.frame_close();
		chk_wr(32'h5A5A_0200, 8'h33);
		// length from register, extra byte refused
		wb_xfer(1'b1, spi_hdr_pkg::REG_LENGTH, 32'h0000_0003, rd);
		spi_host_model_inst.frame_open();
		spi_host_model_inst.send_short(16'h0300, 8'h90, 8'hFF);
		for (int i = 0; i < 4; i++) spi_host_model_inst.xfer(8'h40 + 8'(i), rx);
		spi_host_model_inst.frame_close();
		for (int i = 0; i < 3; i++) chk_wr(32'h1234_0300 + i, 8'h40 + 8'(i));
		chk(32'(q_addr.size()), 32'h0000_0000);
		// long read with auto-increment
		wb_xfer(1'b1, spi_hdr_pkg::REG_CTRL, 32'h0000_0002, rd);
		spi_host_model_inst.frame_open();
		spi_host_model_inst.send_long(32'h8000_00FE, 1'b1, 1'b1, 24'h00_0002);
		spi_host_model_inst.xfer(8'h00, rx);
		chk({24'h00_0000, rx}, {24'h00_0000, mem_val(32'h8000_00FE)});
		chk({31'h0000_0000, miso_oe}, 32'h0000_0001);
		spi_host_model_inst.xfer(8'h00, rx);
		chk({24'h00_0000, rx}, {24'h00_0000, mem_val(32'h8000_00FF)});
		spi_host_model_inst.frame_close();
		chk({31'h0000_0000, miso_oe}, 32'h0000_0000);
		wb_xfer(1'b0, spi_hdr_pkg::REG_STATUS, 32'h0000_0000, rd);
		chk({27'h000_0000, rd[4:0]}, 32'h0000_000C);
		wb_xfer(1'b0, spi_hdr_pkg::REG_LAST_ADDR, 32'h0000_0000, rd);
		chk(rd, 32'h8000_0100);
		chk(32'(q_addr.size()), 32'h0000_0000);
		// long fixed-address write, format switched mid-transaction
		spi_host_model_inst.frame_open();
		spi_host_model_inst.send_long(32'h0001_2345, 1'b0, 1'b0, 24'h00_0002);
		wb_xfer(1'b1, spi_hdr_pkg::REG_CTRL, 32'h0000_0003, rd);
		spi_host_model_inst.xfer(8'hC4, rx);
		spi_host_model_inst.xfer(8'hD5, rx);
		spi_host_model_inst.frame_close();
		chk_wr(32'h0001_2345, 8'hC4);
		chk_wr(32'h0001_2345, 8'hD5);
		// short read, the new format is taken at this frame's start
		spi_host_model_inst.frame_open();
		spi_host_model_inst.send_short(16'h0050, 8'hC0, 8'h01);
		spi_host_model_inst.xfer(8'h00, rx);
		chk({24'h00_0000, rx}, {24'h00_0000, mem_val(32'h1234_0050)});
		spi_host_model_inst.frame_close();
		wb_xfer(1'b0, spi_hdr_pkg::REG_STATUS, 32'h0000_0000, rd);
		chk({27'h000_0000, rd[4:0]}, 32'h0000_000E);
		report_and_stop();
	end
endmodule // spi_hdr_decoder_test

// [bench/spi_host_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// host side of the serial link, mode 0
// ----------------------------------------
module spi_host_model (
	output logic o_sclk,
	output logic o_slave_select_n,
	output logic o_mosi,
	input wire logic i_miso
);
	localparam realtime HALF = 62.5;

	// clock stands low outside frames
	initial begin
		o_sclk = 1'b0;
		o_slave_select_n = 1'b1;
		o_mosi = 1'b1;
	end

	// one byte, msb first, miso taken at the rising edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_mosi = tx[i];
			#HALF o_sclk = 1'b1;
			rx[i] = i_miso;
			#HALF o_sclk = 1'b0;
		end
		// hold time is over, so the stale bit must not linger
		o_mosi = ~o_mosi;
	endtask

	task automatic frame_open();
		o_slave_select_n = 1'b0;
		#HALF;
	endtask

	// long gap so the block sees select high for many clocks
	task automatic frame_close();
		#HALF o_slave_select_n = 1'b1;
		#500;
	endtask

	// address, control, count, most significant byte first
	task automatic send_long(input logic [31:0] adr, input logic inc, input logic rd,
		input logic [23:0] len);
		logic [7:0] rx;
		logic [63:0] hdr;
		hdr = {adr, inc, rd, 6'h00, len};
		for (int i = 7; i >= 0; i--) xfer(hdr[i*8 +: 8], rx);
	endtask

	task automatic send_short(input logic [15:0] adr, input logic [7:0] ctl,
		input logic [7:0] len);
		logic [7:0] rx;
		logic [31:0] hdr;
		hdr = {adr, ctl, len};
		for (int i = 3; i >= 0; i--) xfer(hdr[i*8 +: 8], rx);
	endtask
endmodule // spi_host_model

// [rtl/link_byte_shifter.sv]
`timescale 1ns/1ps

module link_byte_shifter (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_sclk,
	input wire logic i_sel_n,
	input wire logic i_mosi,
	input wire logic [7:0] i_tx_byte,
	output logic o_frame_start,
	output logic o_frame_end,
	output logic o_byte_valid,
	output logic [7:0] o_rx_byte,
	output logic o_miso,
	output logic o_miso_oe
);

	logic sclk_q;
	logic sel_q;
	logic [2:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic rise;
	logic fall;

	// edges only count while selected; mode 0 sampling
	assign rise = i_sclk & ~sclk_q & ~i_sel_n;
	assign fall = ~i_sclk & sclk_q & ~i_sel_n;
	assign o_miso = tx_shift[7];

	// edge history and frame markers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sclk_q <= 1'b0;
			sel_q <= 1'b1;
			o_frame_start <= 1'b0;
			o_frame_end <= 1'b0;
			o_miso_oe <= 1'b0;
		end else begin
			sclk_q <= i_sclk;
			sel_q <= i_sel_n;
			o_frame_start <= sel_q & ~i_sel_n;
			o_frame_end <= ~sel_q & i_sel_n;
			o_miso_oe <= ~i_sel_n;
		end
	end

	// receive side, one byte every eight rising edges
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			bit_cnt <= 3'h0;
			rx_shift <= 8'h00;
			o_rx_byte <= 8'h00;
			o_byte_valid <= 1'b0;
		end else begin
			o_byte_valid <= 1'b0;
			if (i_sel_n) begin
				bit_cnt <= 3'h0; // each select group restarts the byte
			end else if (rise) begin
				rx_shift <= {rx_shift[6:0], i_mosi};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					o_rx_byte <= {rx_shift[6:0], i_mosi};
					o_byte_valid <= 1'b1;
				end
			end
		end
	end

	// transmit side: load late, on the last falling edge of each byte,
	// so that a read fetched after the header still makes it out
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tx_shift <= 8'h00;
		end else if (sel_q & ~i_sel_n) begin
			tx_shift <= i_tx_byte;
		end else if (fall) begin
			if (bit_cnt == 3'h0) begin
				tx_shift <= i_tx_byte;
			end else begin
				tx_shift <= {tx_shift[6:0], 1'b0};
			end
		end
	end

endmodule // link_byte_shifter

// [rtl/pin_sync.sv]
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);

	// ----------------------------------------
	// three stages per bit, accept once 2 and 3 agree
	// ----------------------------------------
	generate
		if (WIDTH < 1) begin : g_bad
			$error("pin_sync needs at least one bit");
		end
		for (genvar b = 0; b < WIDTH; b++) begin : g_bit
			logic s1, s2, s3;
			// s1 only feeds s2, so metastability never reaches the filter
			always_ff @(posedge i_clk_sys) begin
				if (i_rst) begin
					s1 <= RESET_VAL[b];
					s2 <= RESET_VAL[b];
					s3 <= RESET_VAL[b];
					o_level[b] <= RESET_VAL[b];
				end else begin
					s1 <= i_pin[b];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						o_level[b] <= s3;
					end
				end
			end
		end
	endgenerate

endmodule // pin_sync

// [rtl/spi_hdr_decoder.sv]
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps

// How it works
// (RULE1) long control: bit7 auto-increment, bit6 read
// (RULE2) host keeps long control bits 5:0 zero
// (RULE3) short control: same bit7 and bit6 meaning
// (RULE4) short bit5 picks common base upper half
// (RULE5) short bit4 takes length from register
// (RULE6) long header: 4 address, control, 3 length
// (RULE7) short header: 16-bit address under base
// (RULE8) burst and non-burst select framing supported
// (RULE9) one format chosen before, held during transaction
// (RULE10) short length: control low bits above byte
module spi_hdr_decoder (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_sclk,
	input wire logic i_slave_select_n,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	output spi_hdr_pkg::mem_req_t o_mem_req,
	input wire logic i_mem_ack,
	input wire logic [7:0] i_mem_rdata
);

	// ----------------------------------------
	// pins and byte shifter
	// ----------------------------------------
	logic [2:0] pin_level;
	logic frame_start;
	logic frame_end;
	logic byte_valid;
	logic [7:0] rx_byte;
	logic [7:0] rd_byte;

	pin_sync #(
		.WIDTH(3),
		.RESET_VAL(3'b010)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_pin({i_sclk, i_slave_select_n, i_mosi}),
		.o_level(pin_level)
	);

	link_byte_shifter u_shift (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_sclk(pin_level[2]),
		.i_sel_n(pin_level[1]),
		.i_mosi(pin_level[0]),
		.i_tx_byte(rd_byte),
		.o_frame_start(frame_start),
		.o_frame_end(frame_end),
		.o_byte_valid(byte_valid),
		.o_rx_byte(rx_byte),
		.o_miso(o_miso),
		.o_miso_oe(o_miso_oe)
	);

	// ----------------------------------------
	// configuration and state
	// ----------------------------------------
	logic cfg_short;
	logic cfg_burst;
	logic [15:0] base_upper;
	logic [15:0] common_upper;
	logic [11:0] len_reg;
	logic unused_seen;
	spi_hdr_pkg::xfer_state_t state;
	logic active_fmt;
	logic [2:0] hdr_cnt;
	logic hdr_done;
	logic [2:0] hdr_last;
	logic [7:0] hdr_buf [spi_hdr_pkg::LONG_HDR_BYTES];
	spi_hdr_pkg::hdr_t xfer;
	spi_hdr_pkg::hdr_t next_hdr;
	logic [23:0] remaining;
	logic [7:0] ctl;

	assign hdr_last = active_fmt ? spi_hdr_pkg::SHORT_LAST_IDX : spi_hdr_pkg::LONG_LAST_IDX;
	assign ctl = active_fmt ? hdr_buf[spi_hdr_pkg::SHORT_CTL_IDX]
		: hdr_buf[spi_hdr_pkg::LONG_CTL_IDX];

	// header decode, valid in the cycle hdr_done is high
	always_comb begin
		next_hdr.inc = ctl[spi_hdr_pkg::CTL_AUTOINC_BIT]; // see RULE1 see RULE3
		next_hdr.rd = ctl[spi_hdr_pkg::CTL_READ_BIT]; // see RULE1 see RULE3
		if (active_fmt) begin
			// 16-bit address under a designated upper half
			next_hdr.addr = {ctl[spi_hdr_pkg::CTL_COMMON_BIT] ? common_upper : base_upper,
				hdr_buf[0], hdr_buf[1]}; // see RULE4 see RULE7
			if (ctl[spi_hdr_pkg::CTL_LENSRC_BIT]) begin
				next_hdr.len = {12'h000, len_reg}; // see RULE5
			end else begin
				next_hdr.len = {12'h000, ctl[spi_hdr_pkg::CTL_LENHI_MSB:0],
					hdr_buf[spi_hdr_pkg::SHORT_LEN_IDX]}; // see RULE10
			end
		end else begin
			next_hdr.addr = {hdr_buf[0], hdr_buf[1], hdr_buf[2], hdr_buf[3]}; // see RULE6
			next_hdr.len = {hdr_buf[5], hdr_buf[6], hdr_buf[7]}; // see RULE6
		end
	end

	// header capture; the buffer is data and needs no reset
	always_ff @(posedge i_clk_sys) begin
		if (state == spi_hdr_pkg::ST_HEADER && byte_valid && !hdr_done) begin
			hdr_buf[hdr_cnt] <= rx_byte;
		end
	end

	// transaction sequencer
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state <= spi_hdr_pkg::ST_IDLE;
			hdr_cnt <= 3'h0;
			hdr_done <= 1'b0;
			active_fmt <= 1'b0;
			xfer <= '0;
			remaining <= 24'h00_0000;
		end else begin
			hdr_done <= 1'b0;
			case (state)
				spi_hdr_pkg::ST_IDLE: begin
					if (frame_start) begin
						state <= spi_hdr_pkg::ST_HEADER;
						hdr_cnt <= 3'h0;
						active_fmt <= cfg_short; // see RULE9
					end
				end
				spi_hdr_pkg::ST_HEADER: begin
					if (hdr_done) begin
						xfer <= next_hdr;
						remaining <= next_hdr.len;
						state <= (next_hdr.len == 24'h00_0000) ? spi_hdr_pkg::ST_DONE
							: spi_hdr_pkg::ST_DATA;
					end else if (byte_valid) begin
						hdr_cnt <= hdr_cnt + 3'h1;
						if (hdr_cnt == hdr_last) begin
							hdr_done <= 1'b1;
						end
					end
				end
				spi_hdr_pkg::ST_DATA: begin
					if (byte_valid) begin
						remaining <= remaining - 24'h00_0001;
						if (xfer.inc) begin
							xfer.addr <= xfer.addr + 32'h0000_0001;
						end
						if (remaining == 24'h00_0001) begin
							state <= spi_hdr_pkg::ST_DONE;
						end
					end
				end
				spi_hdr_pkg::ST_DONE: begin
					state <= spi_hdr_pkg::ST_DONE; // bytes beyond the length are dropped
				end
				default: begin
					state <= spi_hdr_pkg::ST_IDLE;
				end
			endcase
			// in burst mode select release ends the transaction; in
			// non-burst mode select may rise between bytes
			if (frame_end && (cfg_burst || state == spi_hdr_pkg::ST_DONE)) begin
				state <= spi_hdr_pkg::ST_IDLE; // see RULE8
			end
		end
	end

	// ----------------------------------------
	// internal memory port
	// ----------------------------------------
	// reads run one byte ahead; memory must answer before the next
	// falling sclk edge or the old byte goes out again
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_mem_req <= '0;
			rd_byte <= 8'h00;
		end else begin
			if (o_mem_req.valid && i_mem_ack) begin
				o_mem_req.valid <= 1'b0;
				if (!o_mem_req.we) begin
					rd_byte <= i_mem_rdata;
				end
			end
			if (state == spi_hdr_pkg::ST_HEADER && hdr_done && next_hdr.rd
				&& next_hdr.len != 24'h00_0000) begin
				o_mem_req <= '{valid: 1'b1, we: 1'b0, addr: next_hdr.addr, wdata: 8'h00};
			end else if (state == spi_hdr_pkg::ST_DATA && byte_valid) begin
				if (!xfer.rd) begin
					o_mem_req <= '{valid: 1'b1, we: 1'b1, addr: xfer.addr, wdata: rx_byte};
				end else if (remaining != 24'h00_0001) begin
					o_mem_req <= '{valid: 1'b1, we: 1'b0,
						addr: xfer.addr + {31'h0000_0000, xfer.inc}, wdata: 8'h00};
				end
			end
		end
	end

	// ----------------------------------------
	// wishbone register slave
	// ----------------------------------------
	logic wb_hit;
	logic [31:0] wb_mask;
	logic [31:0] base_word;

	assign wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wb_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	assign base_word = {common_upper, base_upper};

	// software writes, byte lanes honoured
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cfg_short <= spi_hdr_pkg::CTRL_RESET[spi_hdr_pkg::CTRL_SHORT_BIT];
			cfg_burst <= spi_hdr_pkg::CTRL_RESET[spi_hdr_pkg::CTRL_BURST_BIT];
			{common_upper, base_upper} <= spi_hdr_pkg::BASE_RESET;
			len_reg <= spi_hdr_pkg::LENGTH_RESET;
		end else if (wb_hit && i_wb_we) begin
			case (i_wb_adr)
				spi_hdr_pkg::REG_CTRL: begin
					if (i_wb_sel[0]) begin
						cfg_short <= i_wb_dat[spi_hdr_pkg::CTRL_SHORT_BIT];
						cfg_burst <= i_wb_dat[spi_hdr_pkg::CTRL_BURST_BIT];
					end
				end
				spi_hdr_pkg::REG_BASE: begin
					{common_upper, base_upper} <= (base_word & ~wb_mask) | (i_wb_dat & wb_mask);
				end
				spi_hdr_pkg::REG_LENGTH: begin
					len_reg <= (len_reg & ~wb_mask[11:0]) | (i_wb_dat[11:0] & wb_mask[11:0]);
				end
				default: begin
					len_reg <= len_reg;
				end
			endcase
		end
	end

	// host left long control bits 5:0 nonzero; write 1 clears, set wins
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			unused_seen <= 1'b0;
		end else if (state == spi_hdr_pkg::ST_HEADER && hdr_done && !active_fmt
			&& ctl[spi_hdr_pkg::CTL_UNUSED_MSB:0] != 6'h00) begin
			unused_seen <= 1'b1; // see RULE2
		end else if (wb_hit && i_wb_we && i_wb_adr == spi_hdr_pkg::REG_STATUS && i_wb_sel[0]
			&& i_wb_dat[spi_hdr_pkg::STAT_UNUSED_BIT]) begin
			unused_seen <= 1'b0;
		end
	end

	// one wait state answer, unmapped reads give zero
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= wb_hit;
			o_wb_dat <= 32'h0000_0000;
			if (wb_hit && !i_wb_we) begin
				case (i_wb_adr)
					spi_hdr_pkg::REG_CTRL: o_wb_dat <= {30'h0000_0000, cfg_burst, cfg_short};
					spi_hdr_pkg::REG_BASE: o_wb_dat <= base_word;
					spi_hdr_pkg::REG_LENGTH: o_wb_dat <= {20'h0_0000, len_reg};
					spi_hdr_pkg::REG_STATUS: o_wb_dat <= {27'h000_0000, unused_seen, xfer.inc,
						xfer.rd, active_fmt, state != spi_hdr_pkg::ST_IDLE};
					spi_hdr_pkg::REG_LAST_ADDR: o_wb_dat <= xfer.addr;
					spi_hdr_pkg::REG_LAST_LEN: o_wb_dat <= {8'h00, remaining};
					default: o_wb_dat <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	logic decode_now;
	assign decode_now = state == spi_hdr_pkg::ST_HEADER && hdr_done;

	long_ctl_a: assert property (decode_now && !active_fmt |=> // see RULE1
		xfer.inc == $past(hdr_buf[4][7]) && xfer.rd == $past(hdr_buf[4][6]))
		else $error("long control bits decoded wrong");
	short_ctl_a: assert property (decode_now && active_fmt |=> // see RULE3
		xfer.inc == $past(hdr_buf[2][7]) && xfer.rd == $past(hdr_buf[2][6]))
		else $error("short control bits decoded wrong");
	common_base_a: assert property (decode_now && active_fmt |=> // see RULE4
		xfer.addr[31:16] == ($past(hdr_buf[2][5]) ? $past(common_upper) : $past(base_upper)))
		else $error("short upper address half wrong");
	len_source_a: assert property (decode_now && active_fmt && hdr_buf[2][4] |=> // see RULE5
		xfer.len == {12'h000, $past(len_reg)})
		else $error("register length not used");
	long_fields_a: assert property (decode_now && !active_fmt |=> // see RULE6
		xfer.addr == $past({hdr_buf[0], hdr_buf[1], hdr_buf[2], hdr_buf[3]})
		&& xfer.len == $past({hdr_buf[5], hdr_buf[6], hdr_buf[7]}))
		else $error("long address or length wrong");
	short_addr_a: assert property (decode_now && active_fmt |=> // see RULE7
		xfer.addr[15:0] == $past({hdr_buf[0], hdr_buf[1]}))
		else $error("short lower address wrong");
	burst_end_a: assert property (frame_end && cfg_burst |=> // see RULE8
		state == spi_hdr_pkg::ST_IDLE)
		else $error("burst frame did not end transaction");
	fmt_hold_a: assert property (state != spi_hdr_pkg::ST_IDLE // see RULE9
		&& $past(state) != spi_hdr_pkg::ST_IDLE |-> $stable(active_fmt))
		else $error("format changed inside transaction");
	short_len_a: assert property (decode_now && active_fmt && !hdr_buf[2][4] |=> // see RULE10
		xfer.len == {12'h000, $past(hdr_buf[2][3:0]), $past(hdr_buf[3])})
		else $error("short header length wrong");

	write_seen_c: cover property (state == spi_hdr_pkg::ST_DATA && byte_valid && !xfer.rd);
	read_seen_c: cover property (o_mem_req.valid && !o_mem_req.we && i_mem_ack);
	short_done_c: cover property (active_fmt && state == spi_hdr_pkg::ST_DONE);

endmodule // spi_hdr_decoder

// [rtl/spi_hdr_pkg.sv]
package spi_hdr_pkg;

	// ----------------------------------------
	// header layout
	// ----------------------------------------
	localparam int LONG_HDR_BYTES = 8;
	localparam int SHORT_HDR_BYTES = 4;
	localparam int HDR_IDX_W = 3;
	localparam logic [2:0] LONG_LAST_IDX = 3'h7;
	localparam logic [2:0] SHORT_LAST_IDX = 3'h3;
	localparam int LONG_CTL_IDX = 4;
	localparam int SHORT_CTL_IDX = 2;
	localparam int SHORT_LEN_IDX = 3;
	localparam int CTL_AUTOINC_BIT = 7;
	localparam int CTL_READ_BIT = 6;
	localparam int CTL_COMMON_BIT = 5;
	localparam int CTL_LENSRC_BIT = 4;
	localparam int CTL_LENHI_MSB = 3;
	localparam int CTL_UNUSED_MSB = 5;
	localparam int ADDR_W = 32;
	localparam int LEN_W = 24;
	localparam int BASE_W = 16;
	localparam int SHORT_LEN_W = 12;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam int WB_ADR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BASE = 8'h04;
	localparam logic [7:0] REG_LENGTH = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_LAST_ADDR = 8'h10;
	localparam logic [7:0] REG_LAST_LEN = 8'h14;
	localparam int CTRL_SHORT_BIT = 0;
	localparam int CTRL_BURST_BIT = 1;
	localparam int BASE_COMMON_LSB = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FMT_BIT = 1;
	localparam int STAT_READ_BIT = 2;
	localparam int STAT_INC_BIT = 3;
	localparam int STAT_UNUSED_BIT = 4;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam logic [31:0] BASE_RESET = 32'h0000_0000;
	localparam logic [11:0] LENGTH_RESET = 12'h000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic we;
		logic [31:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [23:0] len;
		logic inc;
		logic rd;
	} hdr_t;

	typedef enum {ST_IDLE, ST_HEADER, ST_DATA, ST_DONE} xfer_state_t;

endpackage
